/* rtl/rpt_pkg.sv */
// Constants for the received-power threshold and conversion result register slice.
// Assumes byte-wide register access from the device's 2-wire serial engine.
// Function
// - Set warning when received power high byte is below low threshold high byte.
// - Set warning when received power high byte exceeds high threshold high byte.
// - Low threshold bytes at 0x26/0x27, read/write, reset zero, 16-bit unsigned.
// - Threshold low byte step is 0.1 microwatt; value is unsigned binary.
// - Checksum byte covers page bytes 0 through 94.
// - Checksum at 0x5F is plain storage, never computed, resets to zero.
// - Checksum reads and writes accepted with manufacturer access level.
// - In user level, checksum is readable and writes are ignored.
// - Temperature high byte at 0x60 is read-only, resets zero, one degree per count.
// - Temperature and voltage low bytes always read zero, unused in comparisons.
// - Voltage high byte at 0x62 read-only, resets zero, 25.6 mV per count.
// - Temperature reads zero until the first conversion completes.
package rpt_pkg;

  // Byte addresses within the diagnostic page
  localparam logic [7:0] RPT_OFS_RX_HIGH_THR_HIGH = 8'h24;
  localparam logic [7:0] RPT_OFS_RX_HIGH_THR_LOW = 8'h25;
  localparam logic [7:0] RPT_OFS_RX_LOW_THR_HIGH = 8'h26;
  localparam logic [7:0] RPT_OFS_RX_LOW_THR_LOW = 8'h27;
  localparam logic [7:0] RPT_OFS_PAGE_CHECKSUM = 8'h5F;
  localparam logic [7:0] RPT_OFS_TEMP_HIGH = 8'h60;
  localparam logic [7:0] RPT_OFS_TEMP_LOW = 8'h61;
  localparam logic [7:0] RPT_OFS_VIN_HIGH = 8'h62;
  localparam logic [7:0] RPT_OFS_VIN_LOW = 8'h63;

  // Values after reset and fixed read values
  localparam logic [7:0] RPT_RST_BYTE = 8'h00;
  localparam logic [7:0] RPT_ZERO_BYTE = 8'h00;

  // Register state of the slice
  typedef struct packed {
    logic [7:0] rx_power_high_threshold_high;
    logic [7:0] rx_power_high_threshold_low;
    logic [7:0] rx_power_low_threshold_high;
    logic [7:0] rx_power_low_threshold_low;
    logic [7:0] page_checksum;
    logic [7:0] temperature_result_high;
    logic [7:0] supply_voltage_result_high;
    logic [7:0] rx_power_result_high;
    logic conv_seen;
    logic [7:0] rdata;
    logic rvalid;
    logic warning_flag;
  } rpt_state_t;

endpackage : rpt_pkg

/* rtl/rpt_regs.sv */
// Received-power thresholds, page checksum and conversion result registers.
// Assumes the serial engine presents one-cycle byte read/write strobes with an
// address, and the converter presents results with a one-cycle done strobe.
`timescale 1ns/100ps
`default_nettype none

module rpt_regs (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic manufacturer_access_level,
  input wire logic conv_done,
  input wire logic [7:0] adc_temp_high,
  input wire logic [7:0] adc_vin_high,
  input wire logic [7:0] adc_rx_power_high,
  output logic warning_flag,
  output logic temperature_valid
);
  import rpt_pkg::*;

  rpt_state_t st_ff;
  rpt_state_t nxt_st;

  // Decoded accesses
  logic wr_chk;
  logic wr_ok_chk;
  logic below_low;
  logic above_high;

  // Checksum writes only land at manufacturer level
  assign wr_chk = reg_wr && (reg_addr == RPT_OFS_PAGE_CHECKSUM);
  assign wr_ok_chk = wr_chk && manufacturer_access_level;

  // Only high bytes compare; the threshold low bytes at 0x25 and 0x27 are stored but unused
  // Trade-off: a full 16-bit compare would be cheap, but the result low byte
  // is always zero, so the low bytes could only move the trip point by less
  // than one high-byte step and would surprise a host that leaves them zero
  assign below_low = st_ff.rx_power_result_high < st_ff.rx_power_low_threshold_high;
  assign above_high = st_ff.rx_power_result_high > st_ff.rx_power_high_threshold_high;

  // Next-state logic for every register of the slice
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rvalid = 1'b0;

    // Host writes to read/write thresholds; read-only and unmapped addresses ignore writes
    if (reg_wr) begin
      case (reg_addr)
        RPT_OFS_RX_HIGH_THR_HIGH: begin
          nxt_st.rx_power_high_threshold_high = reg_wdata;
        end
        RPT_OFS_RX_HIGH_THR_LOW: begin
          nxt_st.rx_power_high_threshold_low = reg_wdata;
        end
        RPT_OFS_RX_LOW_THR_HIGH: begin
          nxt_st.rx_power_low_threshold_high = reg_wdata;
        end
        RPT_OFS_RX_LOW_THR_LOW: begin
          nxt_st.rx_power_low_threshold_low = reg_wdata;
        end
        default: begin
        end
      endcase
    end

    // Checksum is host-maintained storage over bytes 0..94; nothing here sums it
    if (wr_ok_chk) begin
      nxt_st.page_checksum = reg_wdata;
    end

    // Results move together on a finished conversion, so reads never see a mix
    // Hazard: the adc_* inputs may change freely between done pulses; only the
    // done cycle is sampled, so stale converter outputs never leak into a read
    if (conv_done) begin
      nxt_st.temperature_result_high = adc_temp_high;
      nxt_st.supply_voltage_result_high = adc_vin_high;
      nxt_st.rx_power_result_high = adc_rx_power_high;
      nxt_st.conv_seen = 1'b1;
    end

    // Read data answers one cycle after the strobe; unmapped reads give zero
    // Limitation: the received power result feeds the compare only and is not
    // mapped for reading here; its address lies outside this slice
    if (reg_rd) begin
      nxt_st.rvalid = 1'b1;
      case (reg_addr)
        RPT_OFS_RX_HIGH_THR_HIGH: begin
          nxt_st.rdata = st_ff.rx_power_high_threshold_high;
        end
        RPT_OFS_RX_HIGH_THR_LOW: begin
          nxt_st.rdata = st_ff.rx_power_high_threshold_low;
        end
        RPT_OFS_RX_LOW_THR_HIGH: begin
          nxt_st.rdata = st_ff.rx_power_low_threshold_high;
        end
        RPT_OFS_RX_LOW_THR_LOW: begin
          nxt_st.rdata = st_ff.rx_power_low_threshold_low;
        end
        RPT_OFS_PAGE_CHECKSUM: begin
          nxt_st.rdata = st_ff.page_checksum;
        end
        RPT_OFS_TEMP_HIGH: begin
          nxt_st.rdata = st_ff.temperature_result_high;
        end
        RPT_OFS_TEMP_LOW: begin
          nxt_st.rdata = RPT_ZERO_BYTE;
        end
        RPT_OFS_VIN_HIGH: begin
          nxt_st.rdata = st_ff.supply_voltage_result_high;
        end
        RPT_OFS_VIN_LOW: begin
          nxt_st.rdata = RPT_ZERO_BYTE;
        end
        default: begin
          nxt_st.rdata = RPT_ZERO_BYTE;
        end
      endcase
    end

    // Warning follows the compare each cycle; a level, not sticky
    nxt_st.warning_flag = below_low || above_high;
  end

  // State register; every field resets to a constant
  // Fields are reset one by one so each byte's reset value stays visible
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff.rx_power_high_threshold_high <= RPT_RST_BYTE;
      st_ff.rx_power_high_threshold_low <= RPT_RST_BYTE;
      st_ff.rx_power_low_threshold_high <= RPT_RST_BYTE;
      st_ff.rx_power_low_threshold_low <= RPT_RST_BYTE;
      st_ff.page_checksum <= RPT_RST_BYTE;
      st_ff.temperature_result_high <= RPT_RST_BYTE;
      st_ff.supply_voltage_result_high <= RPT_RST_BYTE;
      st_ff.rx_power_result_high <= RPT_RST_BYTE;
      st_ff.conv_seen <= 1'b0;
      st_ff.rdata <= RPT_RST_BYTE;
      st_ff.rvalid <= 1'b0;
      st_ff.warning_flag <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state flops
  assign reg_rdata = st_ff.rdata;
  assign reg_rvalid = st_ff.rvalid;
  assign warning_flag = st_ff.warning_flag;
  assign temperature_valid = st_ff.conv_seen;

  // Checks run on ref_clk and are off while reset is held, so the first
  // edge after release only ever compares against the reset values
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // Warning tracks both compares, one cycle behind the result
  a_low_warn: assert property (below_low |=> warning_flag)
    else $error("warning not raised below low threshold");
  a_high_warn: assert property (above_high |=> warning_flag)
    else $error("warning not raised above high threshold");
  a_warn_clear: assert property (!below_low && !above_high |=> !warning_flag)
    else $error("warning raised inside thresholds");

  // Threshold writes land and read back
  a_low_thr_wr: assert property (
    reg_wr && reg_addr == RPT_OFS_RX_LOW_THR_HIGH |=>
      st_ff.rx_power_low_threshold_high == $past(reg_wdata))
    else $error("low threshold high byte write lost");
  a_low_lsb_rd: assert property (
    reg_wr && reg_addr == RPT_OFS_RX_LOW_THR_LOW ##1
      reg_rd && !reg_wr && reg_addr == RPT_OFS_RX_LOW_THR_LOW |=>
      reg_rvalid && reg_rdata == $past(reg_wdata, 2))
    else $error("low threshold low byte readback wrong");

  // Checksum write gating by access level
  a_chk_write: assert property (
    wr_chk && manufacturer_access_level |=> st_ff.page_checksum == $past(reg_wdata))
    else $error("checksum write at manufacturer level lost");
  a_chk_user: assert property (
    wr_chk && !manufacturer_access_level |=> $stable(st_ff.page_checksum))
    else $error("checksum changed by user-level write");
  a_chk_store: assert property (!wr_ok_chk |=> $stable(st_ff.page_checksum))
    else $error("checksum changed without a write");

  // Result bytes: read-only, zero before first conversion, update on done only
  a_temp_ro: assert property (!conv_done |=> $stable(st_ff.temperature_result_high))
    else $error("temperature changed outside a conversion");
  a_temp_first: assert property (!st_ff.conv_seen |-> st_ff.temperature_result_high == 8'h00)
    else $error("temperature nonzero before first conversion");
  a_vin_load: assert property (
    conv_done |=> st_ff.supply_voltage_result_high == $past(adc_vin_high))
    else $error("voltage result not loaded on conversion");
  a_rx_atomic: assert property (!conv_done |=> $stable(st_ff.rx_power_result_high))
    else $error("received power result changed mid-conversion");
  a_low_zero: assert property (
    reg_rd && (reg_addr == RPT_OFS_TEMP_LOW || reg_addr == RPT_OFS_VIN_LOW) |=>
      reg_rvalid && reg_rdata == 8'h00)
    else $error("result low byte read nonzero");

  // Read answer timing: one pulse per strobe, data held between reads
  a_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe without an answer");
  a_rd_single: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read answer without a strobe");
  a_rd_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  // Reads return the byte as it stood at the strobe edge, so a read that
  // meets a write of the same byte in one cycle still sees the old value
  a_high_thr_rd: assert property (
    reg_rd && reg_addr == RPT_OFS_RX_HIGH_THR_HIGH |=>
      reg_rdata == $past(st_ff.rx_power_high_threshold_high))
    else $error("high threshold high byte read wrong");
  a_high_lsb_rd: assert property (
    reg_rd && reg_addr == RPT_OFS_RX_HIGH_THR_LOW |=>
      reg_rdata == $past(st_ff.rx_power_high_threshold_low))
    else $error("high threshold low byte read wrong");
  a_low_thr_rd: assert property (
    reg_rd && reg_addr == RPT_OFS_RX_LOW_THR_HIGH |=>
      reg_rdata == $past(st_ff.rx_power_low_threshold_high))
    else $error("low threshold high byte read wrong");
  a_low_lsb_now: assert property (
    reg_rd && reg_addr == RPT_OFS_RX_LOW_THR_LOW |=>
      reg_rdata == $past(st_ff.rx_power_low_threshold_low))
    else $error("low threshold low byte read wrong");
  a_chk_rd: assert property (
    reg_rd && reg_addr == RPT_OFS_PAGE_CHECKSUM |=>
      reg_rdata == $past(st_ff.page_checksum))
    else $error("checksum read wrong");
  a_temp_rd: assert property (
    reg_rd && reg_addr == RPT_OFS_TEMP_HIGH |=>
      reg_rdata == $past(st_ff.temperature_result_high))
    else $error("temperature read wrong");
  a_vin_rd: assert property (
    reg_rd && reg_addr == RPT_OFS_VIN_HIGH |=>
      reg_rdata == $past(st_ff.supply_voltage_result_high))
    else $error("voltage read wrong");

  // Threshold bytes: each write lands, and nothing else moves them
  a_low_lsb_wr: assert property (
    reg_wr && reg_addr == RPT_OFS_RX_LOW_THR_LOW |=>
      st_ff.rx_power_low_threshold_low == $past(reg_wdata))
    else $error("low threshold low byte write lost");
  a_high_thr_wr: assert property (
    reg_wr && reg_addr == RPT_OFS_RX_HIGH_THR_HIGH |=>
      st_ff.rx_power_high_threshold_high == $past(reg_wdata))
    else $error("high threshold high byte write lost");
  a_high_lsb_wr: assert property (
    reg_wr && reg_addr == RPT_OFS_RX_HIGH_THR_LOW |=>
      st_ff.rx_power_high_threshold_low == $past(reg_wdata))
    else $error("high threshold low byte write lost");
  a_low_thr_hold: assert property (
    !(reg_wr && reg_addr == RPT_OFS_RX_LOW_THR_HIGH) |=>
      $stable(st_ff.rx_power_low_threshold_high))
    else $error("low threshold high byte changed without a write");
  a_low_lsb_hold: assert property (
    !(reg_wr && reg_addr == RPT_OFS_RX_LOW_THR_LOW) |=>
      $stable(st_ff.rx_power_low_threshold_low))
    else $error("low threshold low byte changed without a write");
  a_high_thr_hold: assert property (
    !(reg_wr && reg_addr == RPT_OFS_RX_HIGH_THR_HIGH) |=>
      $stable(st_ff.rx_power_high_threshold_high))
    else $error("high threshold high byte changed without a write");
  a_high_lsb_hold: assert property (
    !(reg_wr && reg_addr == RPT_OFS_RX_HIGH_THR_LOW) |=>
      $stable(st_ff.rx_power_high_threshold_low))
    else $error("high threshold low byte changed without a write");

  // Conversion loads: every result byte and the valid mark move on done
  a_temp_load: assert property (
    conv_done |=> st_ff.temperature_result_high == $past(adc_temp_high))
    else $error("temperature result not loaded on conversion");
  a_rx_load: assert property (
    conv_done |=> st_ff.rx_power_result_high == $past(adc_rx_power_high))
    else $error("received power result not loaded on conversion");
  a_vin_ro: assert property (
    !conv_done |=> $stable(st_ff.supply_voltage_result_high))
    else $error("voltage changed outside a conversion");
  a_valid_set: assert property (conv_done |=> temperature_valid)
    else $error("valid mark not set by a conversion");
  a_valid_keep: assert property (temperature_valid |=> temperature_valid)
    else $error("valid mark dropped without reset");
  a_vin_first: assert property (
    !st_ff.conv_seen |-> st_ff.supply_voltage_result_high == RPT_RST_BYTE)
    else $error("voltage nonzero before first conversion");
  a_rx_first: assert property (
    !st_ff.conv_seen |-> st_ff.rx_power_result_high == RPT_RST_BYTE)
    else $error("received power nonzero before first conversion");

  // Warning depends on the three high bytes only; a change of a low
  // byte alone must leave it where it is
  a_warn_lsb: assert property (
    $stable(st_ff.rx_power_result_high) && $stable(st_ff.rx_power_low_threshold_high) &&
      $stable(st_ff.rx_power_high_threshold_high) |=> $stable(warning_flag))
    else $error("warning moved with the high bytes unchanged");
  a_warn_rise: assert property (
    $rose(warning_flag) |-> $past(below_low || above_high))
    else $error("warning rose without a compare hit");
  a_warn_fall: assert property (
    $fell(warning_flag) |-> !$past(below_low) && !$past(above_high))
    else $error("warning fell while a compare still hit");

endmodule : rpt_regs

`default_nettype wire

/* test/rpt_host.sv */
// Host model: byte reads and writes on the register strobe bus.
// Assumes the bench calls its tasks; it drives only at falling edges.
`timescale 1ns/100ps
`default_nettype none
module rpt_host (
  input wire logic ref_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // Idle bus after time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // One write strobe per byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d; // Released data never repeats the old byte
  endtask : wr
  // Read strobe, then a bounded wait for the answer
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      ok = (reg_rvalid === 1'b1);
      d = reg_rdata;
      if (!ok) @(negedge ref_clk);
    end
  endtask : rd
  // Write strobe, then a read of the same byte on the very next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
    output logic ok);
    ok = 1'b0;
    q = 8'h00;
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      ok = (reg_rvalid === 1'b1);
      q = reg_rdata;
      if (!ok) @(negedge ref_clk);
    end
  endtask : wr_rd
endmodule : rpt_host
`default_nettype wire

/* test/tb_rpt_regs.sv */
// Bench for the threshold, checksum and result register slice.
// Assumes rpt_host owns the register bus; the bench plays the converter.
`timescale 1ns/100ps
`default_nettype none
module tb_rpt_regs;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic mfr = 1'b0;
  logic cdone = 1'b0;
  logic [7:0] t = 8'h00, v = 8'h00, rx = 8'h00, x;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, rvalid, warn, tvalid;
  int failures = 0;
  int checks_done = 0;
  always #20 ref_clk = ~ref_clk;
  rpt_host hst (.ref_clk(ref_clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid));
  rpt_regs uut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(addr), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .manufacturer_access_level(mfr), .conv_done(cdone), .adc_temp_high(t),
    .adc_vin_high(v), .adc_rx_power_high(rx), .warning_flag(warn),
    .temperature_valid(tvalid));
  task automatic conclude();
    if (failures == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // A missing answer ends the run at once
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    hst.rd(a, d, ok);
    if (ok !== 1'b1) begin
      failures++;
      $display("[ERR] %0t no read answer", $time);
      conclude();
    end else begin
      chk(d, exp);
    end
  endtask : rd_chk
  // Write then read on the next cycle; the read must see the new byte
  task automatic wr_rd_chk(input logic [7:0] a, input logic [7:0] val);
    logic [7:0] d;
    logic ok;
    hst.wr_rd(a, val, d, ok);
    if (ok !== 1'b1) begin
      failures++;
      $display("[ERR] %0t no read answer", $time);
      conclude();
    end else begin
      chk(d, val);
    end
  endtask : wr_rd_chk
  function automatic logic exp_warn(input logic [7:0] r, lo, hi);
    return (r < lo) || (r > hi);
  endfunction : exp_warn
  // Program thresholds, run one conversion with stale inputs after it
  task automatic scen(input logic [7:0] lo, hi, lol, r);
    logic [7:0] tt = 8'($urandom);
    logic [7:0] vv = 8'($urandom);
    hst.wr(8'h26, lo);
    hst.wr(8'h27, lol);
    hst.wr(8'h24, hi);
    hst.wr(8'h25, lol);
    t = tt; v = vv; rx = r; cdone = 1'b1;
    @(negedge ref_clk);
    t = ~tt; v = ~vv; rx = ~r; cdone = 1'b0;
    @(negedge ref_clk);
    chk({7'h00, warn}, {7'h00, exp_warn(r, lo, hi)});
    chk({7'h00, tvalid}, 8'h01);
    rd_chk(8'h60, tt);
    rd_chk(8'h61, 8'h00);
    rd_chk(8'h62, vv);
    rd_chk(8'h63, 8'h00);
  endtask : scen
  initial begin
    x = 8'($urandom(32'h3B60));
    repeat (10) @(negedge ref_clk);
    arst_n = 1'b1;
    chk({7'h00, tvalid}, 8'h00);
    // Reset values across the map, one unmapped byte after the checksum and results
    for (int a = 8'h5F; a <= 8'h63; a++) rd_chk(8'(a), 8'h00);
    rd_chk(8'h30, 8'h00);
    for (int a = 8'h24; a <= 8'h27; a++) begin
      rd_chk(8'(a), 8'h00);
      x = 8'($urandom);
      hst.wr(8'(a), x);
      rd_chk(8'(a), x);
    end
    wr_rd_chk(8'h27, 8'($urandom));
    // Checksum is plain storage gated by the access level
    hst.wr(8'h5F, 8'hA5);
    rd_chk(8'h5F, 8'h00);
    mfr = 1'b1;
    hst.wr(8'h5F, 8'h5A);
    rd_chk(8'h5F, 8'h5A);
    mfr = 1'b0;
    rd_chk(8'h5F, 8'h5A);
    // Result bytes ignore writes
    for (int a = 8'h60; a <= 8'h63; a++) begin
      hst.wr(8'(a), 8'hFF);
      rd_chk(8'(a), 8'h00);
    end
    // Boundaries of both compares, then random traffic
    scen(8'h40, 8'hC0, 8'h00, 8'h3F);
    scen(8'h40, 8'hC0, 8'h00, 8'h40);
    scen(8'h40, 8'hC0, 8'h00, 8'hC0);
    scen(8'h40, 8'hC0, 8'h00, 8'hC1);
    scen(8'h00, 8'hFF, 8'hFF, 8'h00);
    repeat (20) scen(8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom));
    // Reset in mid-run wipes thresholds, checksum and results again
    mfr = 1'b1;
    hst.wr(8'h5F, 8'h3C);
    arst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    mfr = 1'b0;
    chk({7'h00, tvalid}, 8'h00);
    chk({7'h00, warn}, 8'h00);
    for (int a = 8'h24; a <= 8'h27; a++) rd_chk(8'(a), 8'h00);
    for (int a = 8'h5F; a <= 8'h63; a++) rd_chk(8'(a), 8'h00);
    conclude();
  end
endmodule : tb_rpt_regs
`default_nettype wire
